// ==== design/pcs_pkg.sv ====
package pcs_pkg;

  // ************************************************************
  // geometry
  // ************************************************************
  localparam int WIDTH = 4;
  localparam int DEPTH = 16;
  localparam int IDX_W = 4;

  localparam logic [IDX_W-1:0] IDX_BOTTOM = 4'h0;
  localparam logic [IDX_W-1:0] IDX_TOP = 4'hF;
  localparam logic [IDX_W-1:0] IDX_ONE = 4'h1;
  localparam logic [WIDTH-1:0] WORD_ZERO = 4'h0;
  localparam logic [WIDTH-1:0] WORD_ONE = 4'h1;
  localparam logic [WIDTH-1:0] WORD_ALL_ONES = 4'hF;

  // ************************************************************
  // default operation decode (configurable at the top)
  // ************************************************************
  localparam logic [1:0] CODE_FETCH = 2'h0;
  localparam logic [1:0] CODE_BRANCH = 2'h1;
  localparam logic [1:0] CODE_CALL = 2'h2;
  localparam logic [1:0] CODE_RETURN = 2'h3;

  // decoded operation, one-hot
  typedef enum logic [3:0] {
    OP_FETCH = 4'b0001,
    OP_BRANCH = 4'b0010,
    OP_CALL = 4'b0100,
    OP_RETURN = 4'b1000
  } pcs_op_type;

  // outward status carried together
  typedef struct packed {
    logic carry_out_n;
    logic stack_full_n;
    logic stack_empty_n;
  } pcs_status_type;

  // pad drive pair for a tri-state bus
  typedef struct packed {
    logic [WIDTH-1:0] value;
    logic [WIDTH-1:0] oe;
  } pcs_bus_drive_type;

  // all state of the slice
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [IDX_W-1:0] stack_index;
    logic [WIDTH-1:0] out_latch;
    logic phase_low_q;
    pcs_bus_drive_type obus;
    pcs_bus_drive_type xbus;
    pcs_status_type status;
  } pcs_state_type;

endpackage

// ==== design/pcs_stack_slice.sv ====
`timescale 1ns/1ns
// ************************************************************
// program counter stack slice
// ************************************************************
// Sampled model: the slice runs on ref_clk; phase_clock, execute_n
// and the other pins are synchronous levels. The low clock phase with
// execute_n low is the "write window"; the low-to-high phase_clock
// transition that ends the window commits the stack index.
module pcs_stack_slice #(
  parameter logic [1:0] FETCH_CODE = pcs_pkg::CODE_FETCH,
  parameter logic [1:0] BRANCH_CODE = pcs_pkg::CODE_BRANCH,
  parameter logic [1:0] CALL_CODE = pcs_pkg::CODE_CALL,
  parameter logic [1:0] RETURN_CODE = pcs_pkg::CODE_RETURN
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // sequencer controls
  input wire logic phase_clock,
  input wire logic execute_n,
  input wire logic [1:0] operation_code_inputs,
  input wire logic master_reset_n,
  input wire logic carry_in_n,
  input wire logic output_bus_enable_n,
  // data in, active high, stored as given
  input wire logic [pcs_pkg::WIDTH-1:0] input_data_bus,
  // output data bus, uninverted latch word, tri-state
  output logic [pcs_pkg::WIDTH-1:0] output_data_bus_n,
  output logic [pcs_pkg::WIDTH-1:0] output_data_bus_oe,
  // address bus, tri-state
  output logic [pcs_pkg::WIDTH-1:0] fetch_address_bus,
  output logic [pcs_pkg::WIDTH-1:0] fetch_address_bus_oe,
  // status
  output logic carry_out_n,
  output logic stack_full_n,
  output logic stack_empty_n
);

  // ************************************************************
  // state
  // ************************************************************
  pcs_pkg::pcs_state_type state_reg;
  pcs_pkg::pcs_state_type state_next;
  pcs_pkg::pcs_op_type op;
  logic write_window;
  logic [pcs_pkg::IDX_W-1:0] mem_addr;
  logic [pcs_pkg::WIDTH-1:0] mem_rd;
  logic [pcs_pkg::WIDTH-1:0] wr_data;
  logic wr_en;

  // operation decode from configurable codes
  always_comb begin
    if (operation_code_inputs == FETCH_CODE) begin
      op = pcs_pkg::OP_FETCH;
    end else if (operation_code_inputs == BRANCH_CODE) begin
      op = pcs_pkg::OP_BRANCH;
    end else if (operation_code_inputs == CALL_CODE) begin
      op = pcs_pkg::OP_CALL;
    end else begin
      op = pcs_pkg::OP_RETURN;
    end
  end

  // ************************************************************
  // datapath
  // ************************************************************
  // write window closes as soon as either clock or execute is high
  assign write_window = !phase_clock && !execute_n;

  // memory address: index, or index +/- 1 while executing call/return
  always_comb begin
    mem_addr = state_reg.stack_index;
    if (!execute_n) begin
      unique case (op)
        pcs_pkg::OP_CALL: mem_addr = state_reg.stack_index + pcs_pkg::IDX_ONE;
        pcs_pkg::OP_RETURN: mem_addr = state_reg.stack_index - pcs_pkg::IDX_ONE;
        default: mem_addr = state_reg.stack_index;
      endcase
    end
  end

  assign mem_rd = state_reg.mem[mem_addr];

  // input multiplexer: incrementor for fetch, data bus otherwise
  always_comb begin
    wr_data = input_data_bus;
    wr_en = 1'b0;
    unique case (op)
      pcs_pkg::OP_FETCH: begin
        // carry in high makes this an iterative fetch
        wr_data = carry_in_n ? state_reg.out_latch
                             : state_reg.out_latch + pcs_pkg::WORD_ONE;
        wr_en = write_window;
      end
      pcs_pkg::OP_BRANCH: wr_en = write_window;
      pcs_pkg::OP_CALL: wr_en = write_window;
      pcs_pkg::OP_RETURN: wr_en = 1'b0;
    endcase
  end

  // next state of the whole slice
  always_comb begin
    state_next = state_reg;
    state_next.phase_low_q = write_window;
    // latches transparent unless the clock is low while executing
    if (!write_window) begin
      state_next.out_latch = mem_rd;
    end
    if (wr_en) begin
      state_next.mem[mem_addr] = wr_data;
    end
    // index commits on the rising clock that ends the window
    if (state_reg.phase_low_q && phase_clock) begin
      unique case (op)
        pcs_pkg::OP_CALL: state_next.stack_index = state_reg.stack_index + pcs_pkg::IDX_ONE;
        pcs_pkg::OP_RETURN: state_next.stack_index = state_reg.stack_index - pcs_pkg::IDX_ONE;
        default: state_next.stack_index = state_reg.stack_index;
      endcase
    end
    // output pads follow the latches
    state_next.obus.value = state_next.out_latch;
    state_next.obus.oe = {pcs_pkg::WIDTH{!output_bus_enable_n}};
    state_next.xbus.value = state_next.out_latch;
    state_next.xbus.oe = {pcs_pkg::WIDTH{write_window && op == pcs_pkg::OP_FETCH}};
    // status from the current memory address and counter word
    state_next.status.carry_out_n = !(state_next.out_latch == pcs_pkg::WORD_ALL_ONES);
    state_next.status.stack_full_n = !(mem_addr == pcs_pkg::IDX_TOP);
    state_next.status.stack_empty_n = !(mem_addr == pcs_pkg::IDX_BOTTOM);
    // master reset overrides the index, latch, address bus and status; output_bus_enable_n still drives the output bus
    if (!master_reset_n) begin
      state_next.stack_index = pcs_pkg::IDX_BOTTOM;
      state_next.mem[pcs_pkg::IDX_BOTTOM] = pcs_pkg::WORD_ZERO;
      state_next.out_latch = pcs_pkg::WORD_ZERO;
      state_next.phase_low_q = 1'b0;
      state_next.xbus.oe = {pcs_pkg::WIDTH{1'b0}};
      state_next.status.stack_empty_n = 1'b0;
      state_next.status.stack_full_n = 1'b1;
      state_next.status.carry_out_n = 1'b1;
    end
  end

  // register the slice; async reset clears all state, output bus enable and whole memory included, with the flags master reset sets
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
      state_reg.status.stack_full_n <= 1'b1;
      state_reg.status.carry_out_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // outputs, straight from flip-flops
  // ************************************************************
  assign output_data_bus_n = state_reg.obus.value;
  assign output_data_bus_oe = state_reg.obus.oe;
  assign fetch_address_bus = state_reg.xbus.value;
  assign fetch_address_bus_oe = state_reg.xbus.oe;
  assign carry_out_n = state_reg.status.carry_out_n;
  assign stack_full_n = state_reg.status.stack_full_n;
  assign stack_empty_n = state_reg.status.stack_empty_n;

endmodule // pcs_stack_slice

// ==== sim/pcs_seq_model.sv ====
`timescale 1ns/1ns
module pcs_seq_model (
  // clock
  input wire logic ref_clk,
  // microcycle controls
  output logic phase_clock,
  output logic execute_n,
  output logic [1:0] operation_code_inputs,
  output logic [3:0] input_data_bus,
  output logic carry_in_n
);
  // idle: phase high, nothing executing
  initial begin
    phase_clock = 1'b1;
    execute_n = 1'b1;
    operation_code_inputs = 2'h0;
    input_data_bus = 4'h0;
    carry_in_n = 1'b0;
  end
  // one microcycle; code held through the rising phase since it commits there
  task automatic run(input logic [1:0] code, input logic [3:0] d, input logic ci, input logic ex);
    @(negedge ref_clk);
    operation_code_inputs = code;
    input_data_bus = d;
    carry_in_n = ci;
    execute_n = ex;
    repeat (2) @(negedge ref_clk);
    phase_clock = 1'b0;
    @(negedge ref_clk);
    phase_clock = 1'b1;
    @(negedge ref_clk);
    execute_n = 1'b1;
    input_data_bus = ~d; // released bus must not keep the old value
    repeat (2) @(negedge ref_clk);
  endtask
endmodule // pcs_seq_model

// ==== sim/pcs_stack_slice_properties.sv ====
`timescale 1ns/1ns
module pcs_stack_slice_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // controls
  input wire logic phase_clock,
  input wire logic execute_n,
  input wire logic [1:0] operation_code_inputs,
  input wire logic master_reset_n,
  input wire logic output_bus_enable_n,
  // outputs
  input wire logic [3:0] output_data_bus_n,
  input wire logic [3:0] output_data_bus_oe,
  input wire logic [3:0] fetch_address_bus_oe,
  input wire logic carry_out_n,
  input wire logic stack_full_n,
  input wire logic stack_empty_n
);
  // ********
  // port checks
  // ********
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // write window: low phase with execute asserted
  wire logic win = !phase_clock && !execute_n;
  chk_obus_on: assert property (!output_bus_enable_n [*2] |-> output_data_bus_oe == 4'hF)
    else $error("output bus not driven");
  chk_obus_off: assert property (output_bus_enable_n [*2] |-> output_data_bus_oe == 4'h0)
    else $error("output bus driven while disabled");
  chk_xbus_fetch: assert property (win && master_reset_n && operation_code_inputs == 2'h0
    |=> fetch_address_bus_oe == 4'hF) else $error("address bus idle in fetch");
  chk_xbus_idle: assert property (fetch_address_bus_oe != 4'h0
    |-> $past(win) && $past(operation_code_inputs) == 2'h0) else $error("address bus stray");
  chk_latch_hold: assert property (win && master_reset_n |=> $stable(output_data_bus_n))
    else $error("latch moved in window");
  chk_flags_excl: assert property (!(!stack_full_n && !stack_empty_n))
    else $error("full and empty together");
  // carry settles once the phase has been high a while
  chk_carry_rest: assert property ((master_reset_n && phase_clock) [*3]
    |-> carry_out_n == (output_data_bus_n != 4'hF)) else $error("carry wrong");
  chk_reset_flags: assert property (!master_reset_n [*2] |-> !stack_empty_n && stack_full_n)
    else $error("flags wrong in master reset");
endmodule // pcs_stack_slice_properties

bind pcs_stack_slice pcs_stack_slice_properties pcs_stack_slice_properties_inst (.*);

// ==== sim/pcs_stack_slice_test.sv ====
`timescale 1ns/1ns
module pcs_stack_slice_test;
  typedef struct packed {logic [3:0] addr; logic full_n; logic empty_n;} pcs_note_type;
  logic ref_clk, nrst, master_reset_n, output_bus_enable_n, phase_clock, execute_n, carry_in_n;
  logic carry_out_n, stack_full_n, stack_empty_n;
  logic oe_seen = 1'b0;
  logic [1:0] operation_code_inputs;
  logic [3:0] input_data_bus, output_data_bus_n, output_data_bus_oe, fetch_address_bus;
  logic [3:0] fetch_address_bus_oe, idx_model;
  logic [3:0] mem_model [16];
  pcs_note_type notes [$];
  pcs_note_type note;
  int n_mismatch = 0;
  int samples_checked = 0;
  // ********
  // bench
  // ********
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  pcs_stack_slice pcs_stack_slice_inst (.*);
  pcs_seq_model pcs_seq_model_inst (.*);
  task automatic check(input logic [5:0] seen, input logic [5:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // request a microcycle and note its effect on the stack model
  task automatic op(input logic [1:0] code, input logic [3:0] d, input logic ci, input logic ex);
    if (!ex) begin
      case (code)
        pcs_pkg::CODE_FETCH: begin
          notes.push_back({mem_model[idx_model], idx_model != 4'hF, idx_model != 4'h0});
          mem_model[idx_model] += {3'h0, !ci};
        end
        pcs_pkg::CODE_BRANCH: mem_model[idx_model] = d;
        pcs_pkg::CODE_CALL: begin
          idx_model += 4'h1;
          mem_model[idx_model] = d;
        end
        default: idx_model -= 4'h1;
      endcase
    end
    pcs_seq_model_inst.run(code, d, ci, ex);
  endtask
  task automatic fetch(input logic ci);
    op(pcs_pkg::CODE_FETCH, 4'h0, ci, 1'b0);
  endtask
  // each fetch shows up once on the address bus; match it with the oldest note
  always @(negedge ref_clk) begin
    if (fetch_address_bus_oe === 4'hF && !oe_seen) begin
      if (notes.size() == 0) check(6'h00, 6'h3F, "stray fetch");
      else begin
        note = notes.pop_front();
        check({fetch_address_bus, stack_full_n, stack_empty_n}, note, "fetch");
        check({5'h00, carry_out_n}, {5'h00, note.addr != 4'hF}, "carry");
        if (output_data_bus_oe === 4'hF) check({output_data_bus_n, 2'h0}, {note.addr, 2'h0}, "obus");
      end
    end
    oe_seen <= fetch_address_bus_oe === 4'hF;
  end
  // main sequence
  initial begin
    nrst = 1'b0;
    master_reset_n = 1'b1;
    output_bus_enable_n = 1'b0;
    idx_model = 4'h0;
    foreach (mem_model[i]) mem_model[i] = 4'h0;
    void'($urandom(99504));
    repeat (3) @(negedge ref_clk);
    nrst = 1'b1;
    fetch(1'b0);
    op(pcs_pkg::CODE_BRANCH, 4'($urandom), 1'b0, 1'b0);
    repeat (2) fetch(1'b0);
    fetch(1'b1);
    op(pcs_pkg::CODE_BRANCH, 4'hF, 1'b0, 1'b1);
    fetch(1'b0);
    op(pcs_pkg::CODE_BRANCH, 4'hF, 1'b0, 1'b0);
    repeat (2) fetch(1'b0);
    for (int i = 0; i < 17; i++) begin
      output_bus_enable_n = 1'($urandom);
      op(pcs_pkg::CODE_CALL, 4'($urandom), 1'b0, 1'b0);
      fetch(1'b0);
    end
    for (int i = 0; i < 18; i++) begin
      op(pcs_pkg::CODE_RETURN, 4'h0, 1'b0, 1'b0);
      fetch(1'b0);
    end
    master_reset_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    master_reset_n = 1'b1;
    idx_model = 4'h0;
    mem_model[0] = 4'h0;
    fetch(1'b0);
    for (int i = 0; i < 20 && notes.size() > 0; i++) @(negedge ref_clk);
    if (notes.size() > 0) check(6'h00, 6'h3F, "missing fetch");
    report_and_stop();
  end
  // hang guard
  initial begin
    #2000000;
    check(6'h00, 6'h3F, "timeout");
    report_and_stop();
  end
endmodule // pcs_stack_slice_test
